// ===== core/sto_monitor_pkg.sv
// Constants for the safe torque off monitor.
// Assumes a 100 MHz system clock.
package sto_monitor_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int TRIG_DELAY_MS = 10;
   localparam int IND_STO_DELAY_MS = 100;
   localparam int IND_DISC_DELAY_MS = 280;
   // Input filter: 1 ms of stable level, well inside the 10 ms cut-off budget
   localparam int FILTER_US = 1000;
   localparam int FILTER_CYCLES = (FILTER_US * (CLK_HZ / 1_000_000));
   // Discrepancy must persist this long before it is declared
   localparam int DISC_CONFIRM_US = 5000;
   localparam int DISC_CYCLES = (DISC_CONFIRM_US * (CLK_HZ / 1_000_000));
   localparam logic [7:0] CODE_NONE = 8'h00;
   localparam logic [7:0] CODE_STO = 8'h28;
   localparam logic [7:0] CODE_CH_A = 8'h29;
   localparam logic [7:0] CODE_CH_B = 8'h2A;
   localparam logic [7:0] CODE_DUAL = 8'h2B;
   localparam int GATE_WIDTH = 6;
   localparam int CNT_WIDTH = 20;
endpackage : sto_monitor_pkg

// ===== core/safe_torque_off_monitor.sv
// Safe torque off monitor: two redundant contact inputs gate the power-stage drive,
// and the fault code and flags tell the controller why the drive was cut.
// Assumes contacts arrive asynchronously and without a defined phase to sys_clk;
// gate requests, start and fault reset come from the motor controller on sys_clk.
// Contact closed reads as 1, so a broken wire reads as open.
//
// Overview of operation
// - Both channels open triggers safe torque off, stops the drive and reports code 40.
// - Both channels closed leaves the drive free to run normally.
// - While running, one channel open and the other closed reports code 41, 42 or 43 by channel.
// - Safe torque off forces every power-stage drive signal inactive.
// - Any trigger cuts drive output within less than 10 ms.
// - A discrepancy fault that arises while running is indicated within less than 280 ms.
// - The dual-open condition is indicated within less than 100 ms.
// - Activation while running reports the fault and coasts; a start while active is refused.
`timescale 1ns/1ns
`default_nettype none
module safe_torque_off_monitor #(
   parameter int FILTER_CYCLES = sto_monitor_pkg::FILTER_CYCLES,
   parameter int DISC_CYCLES = sto_monitor_pkg::DISC_CYCLES
) (
   input wire logic sys_clk, // 100 MHz clock
   input wire logic rst, // Async reset, active high
   input wire logic safetyChannelA, // Contact A, 1 = closed
   input wire logic safetyChannelB, // Contact B, 1 = closed
   input wire logic startCmd, // Run request level
   input wire logic faultReset, // Restart / fault reset pulse
   input wire logic [sto_monitor_pkg::GATE_WIDTH-1:0] gateReq, // Gate drive requests
   output logic [sto_monitor_pkg::GATE_WIDTH-1:0] gateDrive, // Gate drive to power stage
   output logic driveEnable, // Drive output permitted
   output logic stoActive, // Safe torque off indication
   output logic channelAFault, // Channel A exception
   output logic channelBFault, // Channel B exception
   output logic dualChannelFault, // Both channels exception
   output logic [7:0] faultCode // Latched fault code
);
   localparam int CW = sto_monitor_pkg::CNT_WIDTH;

   typedef enum logic [1:0] {RUN_OK, TRIPPED, WAIT_RESET} mode_e;

   typedef struct packed {
      // Two-stage pin synchronisers
      logic [1:0] syncA;
      logic [1:0] syncB;
      // Debounced levels and their timers
      logic fltA;
      logic fltB;
      logic [CW-1:0] cntA;
      logic [CW-1:0] cntB;
      // Mismatch window: age and which channel opened
      logic [CW-1:0] discCnt;
      logic seenA;
      logic seenB;
      // Control and registered outputs
      mode_e mode;
      logic [sto_monitor_pkg::GATE_WIDTH-1:0] gate;
      logic en;
      logic sto;
      logic fA;
      logic fB;
      logic fD;
      logic [7:0] code;
   } state_s;
   state_s s_q, s_d;

   // Safe default: come out of reset tripped, with both channels taken as open
   localparam state_s RESET_STATE = '{
      syncA: 2'h0,
      syncB: 2'h0,
      fltA: 1'b0,
      fltB: 1'b0,
      cntA: '0,
      cntB: '0,
      discCnt: '0,
      seenA: 1'b0,
      seenB: 1'b0,
      mode: TRIPPED,
      gate: '0,
      en: 1'b0,
      sto: 1'b1,
      fA: 1'b0,
      fB: 1'b0,
      fD: 1'b0,
      code: sto_monitor_pkg::CODE_STO
   };

   function automatic logic [CW-1:0] bump(input logic [CW-1:0] c);
      bump = c + CW'(1);
   endfunction : bump

   // Filtered pair as the trip logic sees it
   function automatic logic both_closed(input state_s s);
      both_closed = s.fltA && s.fltB;
   endfunction : both_closed

   function automatic logic both_open(input state_s s);
      both_open = !s.fltA && !s.fltB;
   endfunction : both_open

   always_comb begin
      s_d = s_q;
      s_d.syncA = {s_q.syncA[0], safetyChannelA};
      s_d.syncB = {s_q.syncB[0], safetyChannelB};

      // Debounce each channel; a changed level must hold for the filter time
      if (s_q.syncA[1] == s_q.fltA) begin
         s_d.cntA = '0;
      end else if (s_q.cntA >= CW'(FILTER_CYCLES - 1)) begin
         s_d.fltA = s_q.syncA[1];
         s_d.cntA = '0;
      end else begin
         s_d.cntA = bump(s_q.cntA);
      end
      if (s_q.syncB[1] == s_q.fltB) begin
         s_d.cntB = '0;
      end else if (s_q.cntB >= CW'(FILTER_CYCLES - 1)) begin
         s_d.fltB = s_q.syncB[1];
         s_d.cntB = '0;
      end else begin
         s_d.cntB = bump(s_q.cntB);
      end

      // Remember which channel dropped during a mismatch window
      // The age saturates, so a long mismatch stays confirmed while tripped
      if (s_q.fltA == s_q.fltB) begin
         s_d.discCnt = '0;
         s_d.seenA = 1'b0;
         s_d.seenB = 1'b0;
      end else begin
         if (s_q.discCnt < CW'(DISC_CYCLES)) begin
            s_d.discCnt = bump(s_q.discCnt);
         end
         if (!s_q.fltA) begin
            s_d.seenA = 1'b1;
         end
         if (!s_q.fltB) begin
            s_d.seenB = 1'b1;
         end
      end

      case (s_q.mode)
         RUN_OK: begin
            if (both_open(s_q)) begin
               s_d.mode = TRIPPED;
               s_d.sto = 1'b1;
               s_d.code = sto_monitor_pkg::CODE_STO;
            end else if (s_q.fltA != s_q.fltB) begin
               // Drive is cut at once; the fault is named after confirmation
               s_d.en = 1'b0;
               if (s_q.discCnt >= CW'(DISC_CYCLES)) begin
                  s_d.mode = TRIPPED;
                  if (s_q.seenA && s_q.seenB) begin
                     s_d.fD = 1'b1;
                     s_d.code = sto_monitor_pkg::CODE_DUAL;
                  end else if (!s_q.fltA) begin
                     s_d.fA = 1'b1;
                     s_d.code = sto_monitor_pkg::CODE_CH_A;
                  end else begin
                     s_d.fB = 1'b1;
                     s_d.code = sto_monitor_pkg::CODE_CH_B;
                  end
               end
            end else begin
               // Enable returns only here; gates follow in the same cycle
               s_d.en = 1'b1;
            end
         end
         TRIPPED: begin
            // Start requests are ignored; motor coasts with gates off
            if (both_closed(s_q)) begin
               s_d.mode = WAIT_RESET;
            end else if (both_open(s_q)) begin
               // Both open outranks a latched discrepancy, so STO is shown
               s_d.sto = 1'b1;
               s_d.code = sto_monitor_pkg::CODE_STO;
            end
         end
         WAIT_RESET: begin
            // A channel that opens again re-arms the trip
            if (!both_closed(s_q)) begin
               s_d.mode = TRIPPED;
            end else if (faultReset && !startCmd) begin
               // Reset with run held would restart unexpectedly; demand start released
               s_d.mode = RUN_OK;
               s_d.sto = 1'b0;
               s_d.fA = 1'b0;
               s_d.fB = 1'b0;
               s_d.fD = 1'b0;
               s_d.code = sto_monitor_pkg::CODE_NONE;
            end
         end
         default: begin
            // Unreachable code; fail safe
            s_d.mode = TRIPPED;
         end
      endcase

      if (s_d.mode != RUN_OK) begin
         s_d.en = 1'b0;
      end

      // Gates follow requests only while enabled and both channels closed
      s_d.gate = (s_d.en && both_closed(s_q)) ? gateReq : '0;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_q <= RESET_STATE;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from the state register
   assign gateDrive = s_q.gate;
   assign driveEnable = s_q.en;
   assign stoActive = s_q.sto;
   assign channelAFault = s_q.fA;
   assign channelBFault = s_q.fB;
   assign dualChannelFault = s_q.fD;
   assign faultCode = s_q.code;
endmodule : safe_torque_off_monitor
`default_nettype wire

// ===== sim/sto_contacts.sv
// Contact pair model; a closed contact reads 1, no bounce.
`timescale 1ns/1ns
`default_nettype none
module sto_contacts (
   input wire logic openA, // Open A
   input wire logic openB, // Open B
   output logic safetyChannelA, // Level A
   output logic safetyChannelB); // Level B
   assign {safetyChannelA, safetyChannelB} = ~{openA, openB};
endmodule : sto_contacts
`default_nettype wire

// ===== sim/sto_monitor_props.sv
// Port checker for the monitor; repeat counts assume FILTER_CYCLES of 4.
`timescale 1ns/1ns
`default_nettype none
module sto_monitor_props #(parameter int FILTER_CYCLES = 4, parameter int DISC_CYCLES = 10) (
   input wire logic sys_clk, // Clock
   input wire logic rst, // Reset
   input wire logic safetyChannelA, // A
   input wire logic safetyChannelB, // B
   input wire logic faultReset, // Clear
   input wire logic [5:0] gateDrive, // Gates
   input wire logic driveEnable, // Enable
   input wire logic stoActive, // STO
   input wire logic channelAFault, // A fault
   input wire logic [7:0] faultCode); // Code
   localparam int LIM = FILTER_CYCLES + DISC_CYCLES + 4;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_gate_off: assert property (!driveEnable |-> gateDrive == 6'h00) else $error("gates on");
   a_sto_code: assert property (stoActive |-> faultCode == 8'h28) else $error("sto code");
   a_code_a: assert property (faultCode == 8'h29 |-> channelAFault) else $error("a code");
   a_start_lock: assert property (stoActive |-> !driveEnable) else $error("run in sto");
   a_cut_off: assert property ((!safetyChannelA || !safetyChannelB) [*8] |=> !driveEnable)
      else $error("no cut");
   a_sto_shown: assert property ((!safetyChannelA && !safetyChannelB) [*8] |=> stoActive)
      else $error("sto late");
   a_disc_shown: assert property ($fell(driveEnable) |-> ##[0:LIM] faultCode != 8'h00)
      else $error("fault late");
   a_latch_hold: assert property ($fell(faultCode != 8'h00) |-> faultReset)
      else $error("fault lost");
   cover property (stoActive && !driveEnable);
   cover property ($rose(driveEnable));
   cover property (faultCode == 8'h2B);
endmodule : sto_monitor_props
bind safe_torque_off_monitor sto_monitor_props #(.FILTER_CYCLES(FILTER_CYCLES),
   .DISC_CYCLES(DISC_CYCLES)) props_i (.*);
`default_nettype wire

// ===== sim/tb.sv
// Bench: contact model and monitor with short filter and confirm counts.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
   $display("unexpected %s exp %h got %h", n, e, a); end end
module tb;
   logic sys_clk = 0, rst = 1, openA = 0, openB = 0, startCmd = 0, faultReset = 0;
   logic safetyChannelA, safetyChannelB, driveEnable, stoActive, channelAFault, channelBFault;
   logic dualChannelFault;
   logic [5:0] gateReq = 6'h00, gateDrive;
   logic [7:0] faultCode;
   int n_fail = 0, checks_done = 0;
   wire logic [8:0] st = {driveEnable, faultCode};
   initial forever #5 sys_clk = ~sys_clk;
   sto_contacts sto_contacts_i (.*);
   safe_torque_off_monitor #(.FILTER_CYCLES(4), .DISC_CYCLES(10)) safe_torque_off_monitor_i (.*);
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run
   task automatic wt(input logic [8:0] e);
      for (int w = 0; w < 300; w++) begin
         @(negedge sys_clk);
         if (st === e) break;
      end
      `CHK("state", e, st)
      if (n_fail > 0) complete_run();
   endtask : wt
   task automatic trip(input logic [1:0] o1, o2, input logic [7:0] c, input logic [3:0] f);
      @(posedge sys_clk) {openA, openB, startCmd, faultReset} <= 4'h1;
      wt(9'h100);
      @(posedge sys_clk) {startCmd, faultReset, gateReq} <= 8'hAD;
      repeat (2) @(negedge sys_clk);
      `CHK("gates", 6'h2D, gateDrive)
      @(posedge sys_clk) {openA, openB} <= o1;
      repeat (8) @(posedge sys_clk);
      {openA, openB} <= o2;
      wt({1'b0, c});
      `CHK("flags", f, {stoActive, channelAFault, channelBFault, dualChannelFault})
      `CHK("gates", 6'h00, gateDrive)
      // Start still high and a contact still open, so this clear is ignored
      @(posedge sys_clk) faultReset <= 1'h1;
      repeat (3) @(negedge sys_clk);
      `CHK("held", {1'b0, c}, st)
   endtask : trip
   task automatic start_held;
      @(posedge sys_clk) {openA, openB} <= 2'h3;
      wt(9'h028);
      `CHK("flags", 4'h9, {stoActive, channelAFault, channelBFault, dualChannelFault})
      @(posedge sys_clk) {openA, openB, faultReset} <= 3'h1;
      repeat (20) @(negedge sys_clk);
      `CHK("start held", 9'h028, st)
      @(posedge sys_clk) startCmd <= 1'h0;
      wt(9'h100);
   endtask : start_held
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 0;
      trip(2'h3, 2'h3, 8'h28, 4'h8);
      trip(2'h2, 2'h2, 8'h29, 4'h4);
      trip(2'h1, 2'h1, 8'h2A, 4'h2);
      trip(2'h2, 2'h1, 8'h2B, 4'h1);
      start_held();
      complete_run();
   end
endmodule : tb
`default_nettype wire
